// [core/dhp_pkg.sv]
package dhp_pkg;

  // ==========================================================================
  // Widths and slave register indices
  localparam int         DATA_W       = 8;
  localparam int         SEL_W        = 3;
  localparam int         HOST_CTRL_W  = 5;
  localparam int         SYNC_W       = HOST_CTRL_W + DATA_W;
  localparam int         BUF_DEPTH    = 2;
  localparam logic [2:0] SEL_OUT_CH2  = 3'h0;
  localparam logic [2:0] SEL_STAT_CH2 = 3'h1;
  localparam logic [2:0] SEL_IN_CH2   = 3'h2;
  localparam logic [2:0] SEL_OUT_CH1  = 3'h3;
  localparam logic [2:0] SEL_STAT_CH1 = 3'h4;
  localparam logic [2:0] SEL_IN_CH1   = 3'h5;
  localparam logic [2:0] SEL_IRQ_CTRL = 3'h6;
  localparam logic [2:0] SEL_SYS_CTRL = 3'h7;

  // ==========================================================================
  // Field positions, masks and reset values
  localparam int         BIT_CD          = 3;
  localparam int         BIT_IBF         = 1;
  localparam int         BIT_OBF         = 0;
  localparam int         BIT_IFACE_EN    = 1;
  localparam int         BIT_IRQ_EN_CH2  = 2;
  localparam int         BIT_IRQ_EN_CH1  = 1;
  localparam logic [7:0] USER_MASK       = 8'hF4;
  localparam logic [7:0] STATUS_RESET    = 8'h00;
  localparam logic [7:0] IRQ_CTRL_RESET  = 8'hF8;
  localparam logic [7:0] IRQ_CTRL_MASK   = 8'h07;
  localparam logic [7:0] SYS_CTRL_RESET  = 8'h00;
  localparam logic [7:0] SYS_CTRL_MASK   = 8'h02;
  localparam logic [7:0] BYTE_ZERO       = 8'h00;

  // Positions inside the synchroniser vector
  localparam int SY_CS1 = 12;
  localparam int SY_CS2 = 11;
  localparam int SY_RD  = 10;
  localparam int SY_WR  = 9;
  localparam int SY_A0  = 8;

  typedef logic [SEL_W-1:0] dhp_sel_type;

  typedef enum logic [1:0]
  {
    CH_NONE = 2'b00,
    CH_ONE  = 2'b01,
    CH_TWO  = 2'b10
  } dhp_chan_type;

  // Exactly one chip select low picks a channel
  function automatic dhp_chan_type dhp_decode(input logic cs1_n, input logic cs2_n);
    dhp_chan_type ch;
    ch = CH_NONE;
    if (!cs1_n && cs2_n)
    begin
      ch = CH_ONE;
    end
    else if (cs1_n && !cs2_n)
    begin
      ch = CH_TWO;
    end
    return ch;
  endfunction

endpackage

// [core/dhp_stream_if.sv]
`timescale 1ns/1ps

interface dhp_stream_if #(parameter int WIDTH = 9);

  logic             push_valid;
  logic             push_ready;
  logic [WIDTH-1:0] push_data;
  logic             pop_valid;
  logic             pop_ready;
  logic [WIDTH-1:0] pop_data;
  logic             flush;

  modport fill
  (
    output push_valid,
    output push_data,
    output pop_ready,
    output flush,
    input  push_ready,
    input  pop_valid,
    input  pop_data
  );

  modport store
  (
    input  push_valid,
    input  push_data,
    input  pop_ready,
    input  flush,
    output push_ready,
    output pop_valid,
    output pop_data
  );

endinterface

// [core/dhp_pair_buffer.sv]
`timescale 1ns/1ps

module dhp_pair_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic    clk_in,
  input  wire logic    srst_in,
  dhp_stream_if.store  port
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;
  logic             do_push;
  logic             do_pop;

  assign port.push_ready = (count != CNT_W'(DEPTH));
  assign port.pop_valid  = (count != '0);
  assign port.pop_data   = mem[rd_ptr];
  assign do_push         = port.push_valid && port.push_ready;
  assign do_pop          = port.pop_ready && port.pop_valid;

  // ==========================================================================
  // Storage, cleared so the head reads zero after reset
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem[i] <= '0;
      end
    end
    else if (do_push)
    begin
      mem[wr_ptr] <= port.push_data;
    end
  end

  // ==========================================================================
  // Pointers and fill level; a push and pop together keep the level
  always_ff @(posedge clk_in)
  begin
    if (srst_in || port.flush)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (do_push)
      begin
        wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop)
      begin
        rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
      end
      if (do_push && !do_pop)
      begin
        count <= count + 1'b1;
      end
      else if (do_pop && !do_push)
      begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // dhp_pair_buffer

// [core/dhp_host_port.sv]
`timescale 1ns/1ps
// Behaviour
// - Channel-2 output byte: slave reads and writes it, host only reads it.
// - Output byte driven only with address low, select two low, read low.
// - Channel-2 status clears to zero on reset and in standby.
// - Status bits 7..4 and 2 are spare bits, slave writable, host read.
// - Status bits 3, 1, 0 ignore writes from both sides.
// - Bit 3 captures the address line at each host write; 1 is command.
// - Input-full sets on host write, clears when the slave reads the last buffered input byte.
// - Input-full flag is an interrupt source to the slave processor.
// - Output-full sets on slave write, clears on host read of output byte.
// - Host interface works only while the interface enable bit is one.
// - Enabling the interface takes over the host data and strobe pins.
// - Select one alone: read gives channel-1 data or status by address.
// - Select one alone: write loads channel-1 input, address marks command.
// - Select two alone: read gives channel-2 data or status by address.
// - Select two alone: write loads channel-2 input; strobes never both low.
// - Host data latched into channel-2 input at the write strobe rise.
// - Channel-2 interrupt requested only when enabled and input is full.

module dhp_host_port
  import dhp_pkg::*;
(
  input  wire logic                CLK_IN,
  input  wire logic                SRST_IN,
  input  wire logic                STANDBY_IN,
  input  wire logic                CHIP_SELECT_ONE_N_IN,
  input  wire logic                CHIP_SELECT_TWO_N_IN,
  input  wire logic                HOST_READ_STROBE_N_IN,
  input  wire logic                HOST_WRITE_STROBE_N_IN,
  input  wire logic                HOST_ADDR_LINE_IN,
  input  wire logic [7:0]          HOST_DATA_IN,
  output logic      [7:0]          HOST_DATA_OUT,
  output logic                     HOST_DATA_OE_OUT,
  output logic                     HOST_WR_READY_OUT,
  output logic                     PORT_TAKEN_OUT,
  input  wire dhp_pkg::dhp_sel_type SLV_SEL_IN,
  input  wire logic                SLV_WR_IN,
  input  wire logic                SLV_RD_IN,
  input  wire logic [7:0]          SLV_WDATA_IN,
  output logic      [7:0]          SLV_RDATA_OUT,
  output logic                     IRQ_CH1_OUT,
  output logic                     IRQ_CH2_OUT
);

  import dhp_pkg::*;

  logic [SYNC_W-1:0] sync_1;
  logic [SYNC_W-1:0] sync_2;
  logic [SYNC_W-1:0] sync_3;
  logic [7:0]        out_ch2;
  logic [7:0]        user_ch2;
  logic              cd_ch2;
  logic              obf_ch2;
  logic [7:0]        out_ch1;
  logic [7:0]        in_ch1;
  logic [7:0]        user_ch1;
  logic              cd_ch1;
  logic              ibf_ch1;
  logic              obf_ch1;
  logic [7:0]        irq_ctrl;
  logic [7:0]        sys_ctrl;
  logic [7:0]        status_ch2;
  logic [7:0]        status_ch1;
  logic [7:0]        in_ch2;
  logic              ibf_ch2;
  logic              iface_en;
  logic              clr_state;
  logic              wr_rise;
  logic              rd_rise;
  dhp_chan_type      pin_chan;
  logic              host_wr2;
  logic              host_wr1;
  logic              host_rd_out2;
  logic              host_rd_out1;
  logic              slv_wr_out2;
  logic              slv_wr_out1;
  logic              slv_rd_in2;
  logic              slv_rd_in1;

  dhp_stream_if #(.WIDTH(DATA_W)) in2_if ();

  // ==========================================================================
  // Host pin synchroniser; stage 1 feeds stage 2 only
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      sync_1 <= {{HOST_CTRL_W{1'b1}}, BYTE_ZERO};
      sync_2 <= {{HOST_CTRL_W{1'b1}}, BYTE_ZERO};
      sync_3 <= {{HOST_CTRL_W{1'b1}}, BYTE_ZERO};
    end
    else
    begin
      sync_1 <= {CHIP_SELECT_ONE_N_IN, CHIP_SELECT_TWO_N_IN, HOST_READ_STROBE_N_IN,
                 HOST_WRITE_STROBE_N_IN, HOST_ADDR_LINE_IN, HOST_DATA_IN};
      sync_2 <= sync_1;
      sync_3 <= sync_2;
    end
  end

  // ==========================================================================
  // Decode of the host cycle
  assign iface_en   = sys_ctrl[BIT_IFACE_EN];
  assign clr_state  = SRST_IN || STANDBY_IN;
  assign pin_chan   = dhp_decode(CHIP_SELECT_ONE_N_IN, CHIP_SELECT_TWO_N_IN);
  // Strobe rise seen after the pair of stages
  assign wr_rise    = iface_en && sync_2[SY_WR] && !sync_3[SY_WR];
  assign rd_rise    = iface_en && sync_2[SY_RD] && !sync_3[SY_RD];
  // Select and address are taken from the stage before the rise, while held
  assign host_wr2     = wr_rise && (dhp_decode(sync_3[SY_CS1], sync_3[SY_CS2]) == CH_TWO);
  assign host_wr1     = wr_rise && (dhp_decode(sync_3[SY_CS1], sync_3[SY_CS2]) == CH_ONE);
  assign host_rd_out2 = rd_rise && !sync_3[SY_A0] &&
                        (dhp_decode(sync_3[SY_CS1], sync_3[SY_CS2]) == CH_TWO);
  assign host_rd_out1 = rd_rise && !sync_3[SY_A0] &&
                        (dhp_decode(sync_3[SY_CS1], sync_3[SY_CS2]) == CH_ONE);
  assign slv_wr_out2  = SLV_WR_IN && (SLV_SEL_IN == SEL_OUT_CH2);
  assign slv_wr_out1  = SLV_WR_IN && (SLV_SEL_IN == SEL_OUT_CH1);
  assign slv_rd_in2   = SLV_RD_IN && (SLV_SEL_IN == SEL_IN_CH2);
  assign slv_rd_in1   = SLV_RD_IN && (SLV_SEL_IN == SEL_IN_CH1);

  // ==========================================================================
  // Channel-2 input path through the two-entry buffer
  // Buffer head is the input byte; a second host write waits behind it
  assign in2_if.push_valid = host_wr2;
  assign in2_if.push_data  = sync_3[7:0];
  assign in2_if.pop_ready  = slv_rd_in2;
  assign in2_if.flush      = STANDBY_IN;
  assign in_ch2            = in2_if.pop_data;
  assign ibf_ch2           = in2_if.pop_valid;
  assign HOST_WR_READY_OUT = in2_if.push_ready;

  dhp_pair_buffer #(
    .WIDTH (DATA_W),
    .DEPTH (BUF_DEPTH)
  ) u_in2_buffer (
    .clk_in  (CLK_IN),
    .srst_in (SRST_IN),
    .port    (in2_if)
  );

  // ==========================================================================
  // Channel-2 output byte and status
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      out_ch2 <= BYTE_ZERO;
    end
    else if (slv_wr_out2)
    begin
      out_ch2 <= SLV_WDATA_IN;
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (clr_state)
    begin
      user_ch2 <= STATUS_RESET;
      cd_ch2   <= 1'b0;
      obf_ch2  <= 1'b0;
    end
    else
    begin
      if (SLV_WR_IN && (SLV_SEL_IN == SEL_STAT_CH2))
      begin
        user_ch2 <= SLV_WDATA_IN & USER_MASK;
      end
      if (host_wr2)
      begin
        cd_ch2 <= sync_3[SY_A0];
      end
      // Set wins when a host read lands in the same cycle
      if (slv_wr_out2)
      begin
        obf_ch2 <= 1'b1;
      end
      else if (host_rd_out2)
      begin
        obf_ch2 <= 1'b0;
      end
    end
  end

  assign status_ch2 = user_ch2 | ({7'h00, cd_ch2} << BIT_CD) |
                      ({7'h00, ibf_ch2} << BIT_IBF) | ({7'h00, obf_ch2} << BIT_OBF);

  // ==========================================================================
  // Channel 1, kept single-register
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      out_ch1 <= BYTE_ZERO;
      in_ch1  <= BYTE_ZERO;
    end
    else
    begin
      if (slv_wr_out1)
      begin
        out_ch1 <= SLV_WDATA_IN;
      end
      if (host_wr1)
      begin
        in_ch1 <= sync_3[7:0];
      end
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (clr_state)
    begin
      user_ch1 <= STATUS_RESET;
      cd_ch1   <= 1'b0;
      ibf_ch1  <= 1'b0;
      obf_ch1  <= 1'b0;
    end
    else
    begin
      if (SLV_WR_IN && (SLV_SEL_IN == SEL_STAT_CH1))
      begin
        user_ch1 <= SLV_WDATA_IN & USER_MASK;
      end
      if (host_wr1)
      begin
        cd_ch1 <= sync_3[SY_A0];
      end
      // No buffer here: a write landing on a full register overwrites it
      if (host_wr1)
      begin
        ibf_ch1 <= 1'b1;
      end
      else if (slv_rd_in1)
      begin
        ibf_ch1 <= 1'b0;
      end
      if (slv_wr_out1)
      begin
        obf_ch1 <= 1'b1;
      end
      else if (host_rd_out1)
      begin
        obf_ch1 <= 1'b0;
      end
    end
  end

  assign status_ch1 = user_ch1 | ({7'h00, cd_ch1} << BIT_CD) |
                      ({7'h00, ibf_ch1} << BIT_IBF) | ({7'h00, obf_ch1} << BIT_OBF);

  // ==========================================================================
  // Control registers: interrupt enables and interface enable
  always_ff @(posedge CLK_IN)
  begin
    if (clr_state)
    begin
      irq_ctrl <= IRQ_CTRL_RESET;
    end
    else if (SLV_WR_IN && (SLV_SEL_IN == SEL_IRQ_CTRL))
    begin
      irq_ctrl <= (SLV_WDATA_IN & IRQ_CTRL_MASK) | (IRQ_CTRL_RESET & ~IRQ_CTRL_MASK);
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      sys_ctrl <= SYS_CTRL_RESET;
    end
    else if (SLV_WR_IN && (SLV_SEL_IN == SEL_SYS_CTRL))
    begin
      sys_ctrl <= SLV_WDATA_IN & SYS_CTRL_MASK;
    end
  end

  assign PORT_TAKEN_OUT = iface_en;
  assign IRQ_CH2_OUT    = irq_ctrl[BIT_IRQ_EN_CH2] && ibf_ch2;
  assign IRQ_CH1_OUT    = irq_ctrl[BIT_IRQ_EN_CH1] && ibf_ch1;

  // ==========================================================================
  // Slave read data, one cycle after the read strobe
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      SLV_RDATA_OUT <= BYTE_ZERO;
    end
    else if (SLV_RD_IN)
    begin
      unique case (SLV_SEL_IN)
        SEL_OUT_CH2:  SLV_RDATA_OUT <= out_ch2;
        SEL_STAT_CH2: SLV_RDATA_OUT <= status_ch2;
        SEL_IN_CH2:   SLV_RDATA_OUT <= in_ch2;
        SEL_OUT_CH1:  SLV_RDATA_OUT <= out_ch1;
        SEL_STAT_CH1: SLV_RDATA_OUT <= status_ch1;
        SEL_IN_CH1:   SLV_RDATA_OUT <= in_ch1;
        SEL_IRQ_CTRL: SLV_RDATA_OUT <= irq_ctrl;
        SEL_SYS_CTRL: SLV_RDATA_OUT <= sys_ctrl;
      endcase
    end
  end

  // ==========================================================================
  // Host read drive, straight from the pins so data meets the strobe
  // Both strobes low is illegal, so the bus stays released then
  assign HOST_DATA_OE_OUT = iface_en && !HOST_READ_STROBE_N_IN && HOST_WRITE_STROBE_N_IN &&
                            (pin_chan != CH_NONE);

  always_comb
  begin
    HOST_DATA_OUT = BYTE_ZERO;
    if (pin_chan == CH_TWO)
    begin
      HOST_DATA_OUT = HOST_ADDR_LINE_IN ? status_ch2 : out_ch2;
    end
    else if (pin_chan == CH_ONE)
    begin
      HOST_DATA_OUT = HOST_ADDR_LINE_IN ? status_ch1 : out_ch1;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);

  drive_ch2_data_a: assert property (iface_en && !CHIP_SELECT_TWO_N_IN && CHIP_SELECT_ONE_N_IN &&
    !HOST_READ_STROBE_N_IN && HOST_WRITE_STROBE_N_IN && !HOST_ADDR_LINE_IN
    |-> HOST_DATA_OE_OUT && (HOST_DATA_OUT == out_ch2))
    else $error("channel two data not driven");
  status_clear_a: assert property (STANDBY_IN |=> status_ch2 == STATUS_RESET)
    else $error("status not cleared in standby");
  user_bits_a: assert property (SLV_WR_IN && (SLV_SEL_IN == SEL_STAT_CH2) && !STANDBY_IN
    |=> (status_ch2 & USER_MASK) == ($past(SLV_WDATA_IN) & USER_MASK))
    else $error("spare bits not written");
  ro_bits_a: assert property (SLV_WR_IN && (SLV_SEL_IN == SEL_STAT_CH2) && !host_wr2 &&
    !STANDBY_IN |=> cd_ch2 == $past(cd_ch2))
    else $error("command bit changed by slave write");
  cmd_capture_a: assert property (host_wr2 && !STANDBY_IN |=> cd_ch2 == $past(sync_3[SY_A0]))
    else $error("command bit not captured");
  input_full_a: assert property (host_wr2 && HOST_WR_READY_OUT && !STANDBY_IN |=> ibf_ch2)
    else $error("input full not set");
  input_clear_a: assert property (slv_rd_in2 && !host_wr2 && in2_if.push_ready &&
    ibf_ch2 && !STANDBY_IN |=> !ibf_ch2)
    else $error("input full not cleared");
  irq_gate_a: assert property (IRQ_CH2_OUT |-> ibf_ch2 && irq_ctrl[BIT_IRQ_EN_CH2])
    else $error("interrupt without cause");
  out_full_a: assert property (slv_wr_out2 && !STANDBY_IN |=> obf_ch2 [*1] ##0
    (out_ch2 == $past(SLV_WDATA_IN)))
    else $error("output full not set");
  out_clear_a: assert property (host_rd_out2 && !slv_wr_out2 && !STANDBY_IN |=> !obf_ch2)
    else $error("output full not cleared");
  disabled_a: assert property (!iface_en |-> !HOST_DATA_OE_OUT && !wr_rise ##1 1)
    else $error("host port active while disabled");
  sync_delay_a: assert property ($fell(HOST_WRITE_STROBE_N_IN) |-> !wr_rise ##1 !wr_rise)
    else $error("strobe edge seen too early");

  host_write_c: cover property (host_wr2 ##[1:20] slv_rd_in2);
  buffer_full_c: cover property (!HOST_WR_READY_OUT);
  host_read_c: cover property (slv_wr_out2 ##[1:20] host_rd_out2);
  irq_c: cover property ($rose(IRQ_CH2_OUT));

endmodule // dhp_host_port

// [test/dhp_host_model.sv]
`timescale 1ns/1ps
// ==========================================================================
// Host processor on the eight-bit parallel bus
module dhp_host_model
(
  input  wire logic       clk_in,
  input  wire logic [7:0] bus_in,
  input  wire logic       bus_oe_in,
  output logic            cs_one_n_out,
  output logic            cs_two_n_out,
  output logic            rd_n_out,
  output logic            wr_n_out,
  output logic            addr_out,
  output logic [7:0]      bus_out
);
  initial
  begin
    cs_one_n_out = 1'b1;
    cs_two_n_out = 1'b1;
    rd_n_out     = 1'b1;
    wr_n_out     = 1'b1;
    addr_out     = 1'b0;
    bus_out      = 8'h00;
  end

  // ==========================================================================
  // One access; select, address and data settle well before the strobe rises
  task automatic access(input logic two, input logic a0, input logic wr,
                        input logic [7:0] wdata, output logic [7:0] rdata,
                        output logic oe);
    @(negedge clk_in);
    cs_one_n_out = two;
    cs_two_n_out = !two;
    addr_out     = a0;
    bus_out      = wr ? wdata : ~bus_out;
    rd_n_out     = wr;
    wr_n_out     = !wr;
    repeat (4) @(negedge clk_in);
    rdata        = bus_in;
    oe           = bus_oe_in;
    rd_n_out     = 1'b1;
    wr_n_out     = 1'b1;
    @(negedge clk_in);
    cs_one_n_out = 1'b1;
    cs_two_n_out = 1'b1;
    // Released bus must not keep showing the last byte
    bus_out      = ~bus_out;
    repeat (6) @(negedge clk_in);
  endtask
endmodule // dhp_host_model

// [test/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import dhp_pkg::*;

  logic        clk;
  logic        srst;
  logic        standby;
  logic        cs1_n;
  logic        cs2_n;
  logic        rd_n;
  logic        wr_n;
  logic        a0;
  logic [7:0]  hdin;
  logic [7:0]  hdout;
  logic        oe;
  logic        wr_ready;
  logic        taken;
  dhp_sel_type sel;
  logic        swr;
  logic        srd;
  logic [7:0]  swdata;
  logic [7:0]  srdata;
  logic        irq1;
  logic        irq2;
  int          n_mismatch;
  int          n_tests;
  int          cycles;

  dhp_host_port dhp_host_port_inst (.CLK_IN(clk), .SRST_IN(srst), .STANDBY_IN(standby),
    .CHIP_SELECT_ONE_N_IN(cs1_n), .CHIP_SELECT_TWO_N_IN(cs2_n),
    .HOST_READ_STROBE_N_IN(rd_n), .HOST_WRITE_STROBE_N_IN(wr_n), .HOST_ADDR_LINE_IN(a0),
    .HOST_DATA_IN(hdin), .HOST_DATA_OUT(hdout), .HOST_DATA_OE_OUT(oe),
    .HOST_WR_READY_OUT(wr_ready), .PORT_TAKEN_OUT(taken), .SLV_SEL_IN(sel), .SLV_WR_IN(swr),
    .SLV_RD_IN(srd), .SLV_WDATA_IN(swdata), .SLV_RDATA_OUT(srdata), .IRQ_CH1_OUT(irq1),
    .IRQ_CH2_OUT(irq2));

  dhp_host_model dhp_host_model_inst (.clk_in(clk), .bus_in(hdout), .bus_oe_in(oe),
    .cs_one_n_out(cs1_n), .cs_two_n_out(cs2_n), .rd_n_out(rd_n), .wr_n_out(wr_n),
    .addr_out(a0), .bus_out(hdin));

  // ==========================================================================
  // Clock, timeout and report
  always #5 clk = ~clk;

  always @(posedge clk)
  begin
    cycles++;
    // Whole run needs well under a thousand cycles
    if (cycles == 3000)
    begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic test_done();
    if (n_mismatch == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // ==========================================================================
  // Slave and host accesses
  task automatic slv_wr(input dhp_sel_type s, input logic [7:0] d);
    @(negedge clk);
    sel    = s;
    swdata = d;
    swr    = 1'b1;
    @(negedge clk);
    swr    = 1'b0;
  endtask

  task automatic slv_rd(input dhp_sel_type s, input logic [7:0] exp, input string name);
    @(negedge clk);
    sel = s;
    srd = 1'b1;
    @(negedge clk);
    srd = 1'b0;
    check(name, srdata, exp);
  endtask

  task automatic host_wr(input logic two, input logic addr, input logic [7:0] d);
    logic [7:0] rd;
    logic       drv;
    dhp_host_model_inst.access(two, addr, 1'b1, d, rd, drv);
    check("oe_during_write", {7'h00, drv}, 8'h00);
  endtask

  task automatic host_rd(input logic two, input logic addr, input logic [7:0] exp,
                         input string name);
    logic [7:0] rd;
    logic       drv;
    dhp_host_model_inst.access(two, addr, 1'b0, 8'h00, rd, drv);
    check(name, rd, exp);
    check("oe_during_read", {7'h00, drv}, 8'h01);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    slv_rd(SEL_STAT_CH2, 8'h00, "status2_reset");
    slv_rd(SEL_IRQ_CTRL, 8'hF8, "irq_ctrl_reset");
    slv_rd(SEL_SYS_CTRL, 8'h00, "sys_ctrl_reset");
    check("taken_reset", {7'h00, taken}, 8'h00);
  endtask

  task automatic t_enable();
    host_wr(1'b1, 1'b0, 8'h11);
    slv_rd(SEL_STAT_CH2, 8'h00, "write_while_off");
    slv_wr(SEL_SYS_CTRL, 8'hFF);
    slv_rd(SEL_SYS_CTRL, 8'h02, "sys_ctrl_bits");
    check("taken_on", {7'h00, taken}, 8'h01);
  endtask

  task automatic t_output();
    slv_wr(SEL_OUT_CH2, 8'hA5);
    slv_rd(SEL_OUT_CH2, 8'hA5, "out2_slave");
    slv_rd(SEL_STAT_CH2, 8'h01, "obf_set");
    // A status read must not clear the output-full flag
    host_rd(1'b1, 1'b1, 8'h01, "host_status2");
    host_rd(1'b1, 1'b0, 8'hA5, "host_out2");
    slv_rd(SEL_STAT_CH2, 8'h00, "obf_clear");
  endtask

  task automatic t_spare();
    slv_wr(SEL_STAT_CH2, 8'hFF);
    slv_rd(SEL_STAT_CH2, 8'hF4, "spare_set");
    host_rd(1'b1, 1'b1, 8'hF4, "host_spare");
    slv_wr(SEL_STAT_CH2, 8'h00);
    slv_rd(SEL_STAT_CH2, 8'h00, "spare_clear");
  endtask

  task automatic t_input();
    host_wr(1'b1, 1'b1, 8'h3C);
    slv_rd(SEL_STAT_CH2, 8'h0A, "cmd_write");
    check("irq2_masked", {7'h00, irq2}, 8'h00);
    slv_wr(SEL_IRQ_CTRL, 8'h04);
    slv_rd(SEL_IRQ_CTRL, 8'hFC, "irq_ctrl_rw");
    check("irq2_on", {7'h00, irq2}, 8'h01);
    host_wr(1'b1, 1'b0, 8'hC3);
    slv_rd(SEL_STAT_CH2, 8'h02, "data_write");
    check("buffer_full", {7'h00, wr_ready}, 8'h00);
    // Third byte finds no room and is dropped
    host_wr(1'b1, 1'b0, 8'h77);
    slv_rd(SEL_IN_CH2, 8'h3C, "in2_first");
    slv_rd(SEL_STAT_CH2, 8'h02, "ibf_still");
    slv_rd(SEL_IN_CH2, 8'hC3, "in2_second");
    slv_rd(SEL_STAT_CH2, 8'h00, "ibf_clear");
    check("irq2_off", {7'h00, irq2}, 8'h00);
    check("buffer_room", {7'h00, wr_ready}, 8'h01);
    slv_rd(SEL_OUT_CH2, 8'hA5, "out2_kept");
  endtask

  task automatic t_chan1();
    slv_wr(SEL_IRQ_CTRL, 8'h06);
    slv_wr(SEL_OUT_CH1, 8'h96);
    host_rd(1'b0, 1'b1, 8'h01, "host_status1");
    host_rd(1'b0, 1'b0, 8'h96, "host_out1");
    host_wr(1'b0, 1'b1, 8'h5A);
    slv_rd(SEL_STAT_CH1, 8'h0A, "status1_cmd");
    check("irq1_on", {7'h00, irq1}, 8'h01);
    slv_rd(SEL_IN_CH1, 8'h5A, "in1_byte");
    check("irq1_off", {7'h00, irq1}, 8'h00);
    slv_rd(SEL_STAT_CH2, 8'h00, "ch2_untouched");
  endtask

  task automatic t_standby();
    host_wr(1'b1, 1'b1, 8'h11);
    slv_wr(SEL_STAT_CH2, 8'hF0);
    @(negedge clk);
    standby = 1'b1;
    repeat (2) @(negedge clk);
    standby = 1'b0;
    slv_rd(SEL_STAT_CH2, 8'h00, "status2_standby");
    slv_rd(SEL_IRQ_CTRL, 8'hF8, "irq_ctrl_standby");
    check("irq2_standby", {7'h00, irq2}, 8'h00);
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    clk        = 1'b0;
    srst       = 1'b1;
    standby    = 1'b0;
    sel        = SEL_OUT_CH2;
    swr        = 1'b0;
    srd        = 1'b0;
    swdata     = 8'h00;
    n_mismatch = 0;
    n_tests    = 0;
    cycles     = 0;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    t_reset();
    t_enable();
    t_output();
    t_spare();
    t_input();
    t_chan1();
    t_standby();
    test_done();
  end
endmodule // tb_top
